// *** audpg_regs.svh ***
`ifndef AUDPG_REGS_SVH
`define AUDPG_REGS_SVH

// ============================================================
// Register indices (byte address is four times the index)
// ============================================================
`define AUDPG_PWR0_IDX      30'h0000f050
`define AUDPG_PWR1_IDX      30'h0000f051
`define AUDPG_SEL_IDX_FIRST 30'h0000f100
`define AUDPG_SEL_IDX_LAST  30'h0000f107
`define AUDPG_SEL_COUNT     8
`define AUDPG_SEL_AW        3

// ============================================================
// Field layouts and reset values
// ============================================================
`define AUDPG_PWR0_W        3
`define AUDPG_PWR1_W        5
`define AUDPG_PWR0_RESET    3'h0
`define AUDPG_PWR1_RESET    5'h00
`define AUDPG_SEL_W         8
`define AUDPG_SEL_RESET     8'h00
`define AUDPG_SEL_KIND_LSB  0
`define AUDPG_SEL_KIND_W    3
`define AUDPG_SEL_PAIR_LSB  3
`define AUDPG_SEL_PAIR_W    5
`define AUDPG_SEL_PAIR_MAX  5'h17
`define AUDPG_MIC_B_BIT     4
`define AUDPG_MIC_A_BIT     3
`define AUDPG_TX_BIT        2
`define AUDPG_RX_BIT        1
`define AUDPG_ADC_BIT       0

`endif

// *** audpg_pkg.sv ***
package audpg_pkg;

  typedef enum logic [2:0] {
    kind_unused = 3'h0,
    kind_serial = 3'h1,
    kind_core   = 3'h2,
    kind_rx     = 3'h3,
    kind_mic_a  = 3'h4,
    kind_mic_b  = 3'h5
  } audpg_kind_t;

  typedef struct packed {
    logic mic_pair_b_power;
    logic mic_pair_a_power;
    logic digital_audio_transmitter_power;
    logic digital_audio_receiver_power;
    logic aux_converter_power;
  } audpg_power_t;

  typedef struct packed {
    logic        valid;
    audpg_kind_t converter_source_kind;
    logic [4:0]  converter_serial_pair_select;
    logic [5:0]  first_serial_channel;
  } audpg_conv_sel_t;

  typedef enum logic [1:0] {
    bus_idle   = 2'h0,
    bus_rd_mem = 2'h1,
    bus_rd_out = 2'h2
  } audpg_bus_state_t;

endpackage

// *** audpg_hold.sv ***
`timescale 1ns/1ns

// Sample register that freezes on its last value while disabled.
module audpg_hold #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         enable,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= '0;
    end else if (enable) begin
      dout <= din;
    end
  end

endmodule

// *** audpg_sel_mem.sv ***
`timescale 1ns/1ns

// Small register-file memory; every word is also visible in parallel.
module audpg_sel_mem #(
  parameter int DEPTH = 8,
  parameter int W     = 8,
  parameter int AW    = 3
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               we,
  input  wire logic [AW-1:0]      waddr,
  input  wire logic [W-1:0]       wdata,
  input  wire logic [AW-1:0]      raddr,
  output logic      [W-1:0]       rdata,
  output logic      [DEPTH*W-1:0] words
);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      words <= '0;
    end else if (we) begin
      words[waddr*W +: W] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= words[raddr*W +: W];
    end
  end

endmodule

// *** audpg_top.sv ***
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "audpg_regs.svh"

module audpg_top #(
  parameter int MIC_W  = 24,
  parameter int ADC_CH = 4,
  parameter int ADC_W  = 12
) (
  input  wire logic                               hclk,
  input  wire logic                               hresetn,
  input  wire logic                               hsel,
  input  wire logic [31:0]                        haddr,
  input  wire logic [1:0]                         htrans,
  input  wire logic                               hwrite,
  input  wire logic [2:0]                         hsize,
  input  wire logic [31:0]                        hwdata,
  input  wire logic                               hready,
  output logic                                    hreadyout,
  output logic [31:0]                             hrdata,
  output logic                                    hresp,
  input  wire logic [2:0]                         serial_input_data_pin,
  input  wire logic [2:0]                         input_frame_clock_pin,
  input  wire logic [2:0]                         input_bit_clock_pin,
  output logic [2:0]                              serial_input_data,
  output logic [2:0]                              input_frame_clock,
  output logic [2:0]                              input_bit_clock,
  output logic [2:0]                              serial_in_path_power,
  output audpg_pkg::audpg_power_t                 block_power,
  input  wire logic [4*MIC_W-1:0]                 mic_data_in,
  output logic [4*MIC_W-1:0]                      mic_data_out,
  input  wire logic                               tx_stream,
  output logic                                    tx_pin,
  input  wire logic                               rx_pin,
  output logic                                    rx_stream,
  input  wire logic [ADC_CH*ADC_W-1:0]            adc_result_in,
  output logic [ADC_CH*ADC_W-1:0]                 adc_result_out,
  output audpg_pkg::audpg_conv_sel_t [`AUDPG_SEL_COUNT-1:0] conv_sel
);

  // ============================================================
  // Address and selector decode helpers
  // ============================================================
  function automatic logic is_sel_idx(input logic [29:0] idx);
    return (idx >= `AUDPG_SEL_IDX_FIRST) && (idx <= `AUDPG_SEL_IDX_LAST);
  endfunction

  // Out-of-range codes fall back to unused, so a converter is never fed from a source that does not exist.
  function automatic audpg_pkg::audpg_conv_sel_t decode_sel(input logic [`AUDPG_SEL_W-1:0] raw);
    audpg_pkg::audpg_conv_sel_t r;
    logic [2:0]                 kind;
    logic [4:0]                 pair;
    kind = raw[`AUDPG_SEL_KIND_LSB +: `AUDPG_SEL_KIND_W];
    pair = raw[`AUDPG_SEL_PAIR_LSB +: `AUDPG_SEL_PAIR_W];
    r = '0;
    r.converter_source_kind = audpg_pkg::kind_unused;
    if (kind == audpg_pkg::kind_serial && pair <= `AUDPG_SEL_PAIR_MAX) begin
      r.valid = 1'b1;
      r.converter_source_kind = audpg_pkg::kind_serial;
      r.converter_serial_pair_select = pair;
      r.first_serial_channel = {pair, 1'b0};
    end else if (kind >= audpg_pkg::kind_core && kind <= audpg_pkg::kind_mic_b) begin
      r.valid = 1'b1;
      r.converter_source_kind = audpg_pkg::audpg_kind_t'(kind);
    end
    return r;
  endfunction

  // ============================================================
  // AHB-Lite slave
  // ============================================================
  audpg_pkg::audpg_bus_state_t state;
  audpg_pkg::audpg_bus_state_t next_state;
  logic [29:0]                 addr_q;
  logic                        wr_pend;
  logic [`AUDPG_PWR0_W-1:0]    pwr0;
  logic [`AUDPG_SEL_W-1:0]     mem_rdata;
  logic [`AUDPG_SEL_COUNT*`AUDPG_SEL_W-1:0] sel_words;

  wire accept     = hsel && htrans[1] && hready;
  wire rd_accept  = accept && !hwrite;
  wire wr_fire    = wr_pend && hready;
  wire hit_pwr0   = (addr_q == `AUDPG_PWR0_IDX);
  wire hit_pwr1   = (addr_q == `AUDPG_PWR1_IDX);
  wire hit_sel    = is_sel_idx(addr_q);
  wire sel_we     = wr_fire && hit_sel;
  wire [`AUDPG_SEL_AW-1:0] sel_index = addr_q[`AUDPG_SEL_AW-1:0];
  wire [31:0] read_mux = hit_pwr0 ? {29'h0, pwr0} :
                         hit_pwr1 ? {27'h0, block_power} :
                         hit_sel  ? {24'h0, mem_rdata} : 32'h0;

  always_comb begin
    next_state = state;
    case (state)
      audpg_pkg::bus_idle: begin
        if (rd_accept) begin
          next_state = audpg_pkg::bus_rd_mem;
        end
      end
      audpg_pkg::bus_rd_mem: begin
        next_state = audpg_pkg::bus_rd_out;
      end
      audpg_pkg::bus_rd_out: begin
        next_state = audpg_pkg::bus_idle;
      end
      default: begin
        next_state = audpg_pkg::bus_idle;
      end
    endcase
  end

  // Reads take two wait states so that hrdata leaves a flop and never races a write completing alongside.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= audpg_pkg::bus_idle;
      addr_q    <= 30'h0;
      wr_pend   <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0;
      hresp     <= 1'b0;
    end else begin
      state <= next_state;
      if (accept) begin
        addr_q <= haddr[31:2];
      end
      if (accept) begin
        wr_pend <= hwrite;
      end else if (hready) begin
        wr_pend <= 1'b0;
      end
      if (rd_accept) begin
        hreadyout <= 1'b0;
      end else if (state == audpg_pkg::bus_rd_out) begin
        hreadyout <= 1'b1;
        hrdata    <= read_mux;
      end
    end
  end

  // ============================================================
  // Power registers
  // ============================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr0        <= `AUDPG_PWR0_RESET;
      block_power <= `AUDPG_PWR1_RESET;
    end else if (wr_fire && hit_pwr0) begin
      pwr0 <= hwdata[`AUDPG_PWR0_W-1:0];
    end else if (wr_fire && hit_pwr1) begin
      block_power <= audpg_pkg::audpg_power_t'(hwdata[`AUDPG_PWR1_W-1:0]);
    end
  end

  // ============================================================
  // Serial input paths
  // ============================================================
  logic [2:0] data_s1;
  logic [2:0] data_s2;
  logic [2:0] frame_s1;
  logic [2:0] bit_s1;

  // Clocks keep passing while the data path is gated, since other ports may share them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_s1              <= 3'h0;
      data_s2              <= 3'h0;
      frame_s1             <= 3'h0;
      bit_s1               <= 3'h0;
      input_frame_clock    <= 3'h0;
      input_bit_clock      <= 3'h0;
      serial_input_data    <= 3'h0;
      serial_in_path_power <= 3'h0;
    end else begin
      data_s1              <= serial_input_data_pin;
      data_s2              <= data_s1;
      frame_s1             <= input_frame_clock_pin;
      bit_s1               <= input_bit_clock_pin;
      input_frame_clock    <= frame_s1;
      input_bit_clock      <= bit_s1;
      serial_input_data    <= data_s2 & pwr0;
      serial_in_path_power <= pwr0;
    end
  end

  // ============================================================
  // Microphone, transmitter, receiver, auxiliary converters
  // ============================================================
  logic rx_s1;
  logic rx_s2;

  audpg_hold #(.W(2*MIC_W)) u_mic_a (
    .clk    (hclk),
    .rst_n  (hresetn),
    .enable (block_power.mic_pair_a_power),
    .din    (mic_data_in[2*MIC_W-1:0]),
    .dout   (mic_data_out[2*MIC_W-1:0])
  );

  audpg_hold #(.W(2*MIC_W)) u_mic_b (
    .clk    (hclk),
    .rst_n  (hresetn),
    .enable (block_power.mic_pair_b_power),
    .din    (mic_data_in[4*MIC_W-1:2*MIC_W]),
    .dout   (mic_data_out[4*MIC_W-1:2*MIC_W])
  );

  audpg_hold #(.W(ADC_CH*ADC_W)) u_adc (
    .clk    (hclk),
    .rst_n  (hresetn),
    .enable (block_power.aux_converter_power),
    .din    (adc_result_in),
    .dout   (adc_result_out)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_pin    <= 1'b0;
      rx_s1     <= 1'b0;
      rx_s2     <= 1'b0;
      rx_stream <= 1'b0;
    end else begin
      tx_pin    <= tx_stream & block_power.digital_audio_transmitter_power;
      rx_s1     <= rx_pin;
      rx_s2     <= rx_s1;
      rx_stream <= rx_s2 & block_power.digital_audio_receiver_power;
    end
  end

  // ============================================================
  // Converter source selectors
  // ============================================================
  audpg_sel_mem #(
    .DEPTH (`AUDPG_SEL_COUNT),
    .W     (`AUDPG_SEL_W),
    .AW    (`AUDPG_SEL_AW)
  ) u_sel (
    .clk   (hclk),
    .rst_n (hresetn),
    .we    (sel_we),
    .waddr (sel_index),
    .wdata (hwdata[`AUDPG_SEL_W-1:0]),
    .raddr (sel_index),
    .rdata (mem_rdata),
    .words (sel_words)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_sel <= '0;
    end else begin
      for (int n = 0; n < `AUDPG_SEL_COUNT; n++) begin
        conv_sel[n] <= decode_sel(sel_words[n*`AUDPG_SEL_W +: `AUDPG_SEL_W]);
      end
    end
  end

  // ============================================================
  // Assertions
  // ============================================================
  logic bad_pair;
  always_comb begin
    bad_pair = 1'b0;
    for (int n = 0; n < `AUDPG_SEL_COUNT; n++) begin
      if (conv_sel[n].valid && conv_sel[n].first_serial_channel > 6'h2e) begin
        bad_pair = 1'b1;
      end
    end
  end

  chk_path_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 ((serial_input_data & ~$past(pwr0)) == 3'h0)) else $error("disabled serial path passed data");
  chk_clock_free: assert property (@(posedge hclk) disable iff (!hresetn)
    ##2 (input_frame_clock == $past(input_frame_clock_pin, 2))) else $error("frame clock was gated");
  chk_pwr1_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_fire && hit_pwr1) |=> (block_power == $past(hwdata[4:0]))) else $error("power register write lost");
  chk_mic_b_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !block_power.mic_pair_b_power |=> $stable(mic_data_out[4*MIC_W-1:2*MIC_W])) else $error("mic pair b updated");
  chk_mic_a_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !block_power.mic_pair_a_power |=> $stable(mic_data_out[2*MIC_W-1:0])) else $error("mic pair a updated");
  chk_tx_low: assert property (@(posedge hclk) disable iff (!hresetn)
    !block_power.digital_audio_transmitter_power |=> !tx_pin) else $error("transmit pin not held low");
  chk_rx_halt: assert property (@(posedge hclk) disable iff (!hresetn)
    !block_power.digital_audio_receiver_power |=> !rx_stream) else $error("receiver kept running");
  chk_adc_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !block_power.aux_converter_power |=> $stable(adc_result_out)) else $error("aux result updated");
  chk_sel_write: assert property (@(posedge hclk) disable iff (!hresetn)
    sel_we |=> ##1 (conv_sel[$past(sel_index, 2)] == decode_sel($past(hwdata[7:0], 2)))) else $error("selector lost");
  chk_pair_range: assert property (@(posedge hclk) disable iff (!hresetn)
    !bad_pair) else $error("serial pair beyond channel 47");
  chk_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_accept |=> !hreadyout ##1 !hreadyout ##1 hreadyout) else $error("read latency wrong");

  cov_pwr1_write: cover property (@(posedge hclk) disable iff (!hresetn) wr_fire && hit_pwr1);
  cov_sel_read: cover property (@(posedge hclk) disable iff (!hresetn) rd_accept ##3 hit_sel);
  cov_serial_src: cover property (@(posedge hclk) disable iff (!hresetn)
    conv_sel[0].valid && conv_sel[0].converter_source_kind == audpg_pkg::kind_serial);

endmodule

// *** audio_power_gating_and_asrc_input_select_tb.sv ***
`timescale 1ns/1ns
`include "audpg_regs.svh"

module audio_power_gating_and_asrc_input_select_tb;
  // ============================================================
  // Signals and instance
  // ============================================================
  localparam logic [31:0] A_PWR0 = {`AUDPG_PWR0_IDX, 2'b00};
  localparam logic [31:0] A_PWR1 = {`AUDPG_PWR1_IDX, 2'b00};
  localparam logic [31:0] A_SEL  = {`AUDPG_SEL_IDX_FIRST, 2'b00};

  logic                                     hclk      = 1'b0;
  logic                                     hresetn   = 1'b0;
  logic                                     hsel      = 1'b0;
  logic                                     hwrite    = 1'b0;
  logic [1:0]                               htrans    = 2'h0;
  logic [2:0]                               hsize     = 3'h2;
  logic [31:0]                              haddr     = 32'h0;
  logic [31:0]                              hwdata    = 32'h0;
  logic [2:0]                               sd_pin    = 3'h0;
  logic [2:0]                               fc_pin    = 3'h0;
  logic [2:0]                               bc_pin    = 3'h0;
  logic [95:0]                              mic_in    = 96'h0;
  logic [47:0]                              adc_in    = 48'h0;
  logic                                     tx_stream = 1'b0;
  logic                                     rx_pin    = 1'b0;
  logic                                     rd_busy   = 1'b0;
  wire                                      hready;
  wire                                      hreadyout;
  wire                                      hresp;
  wire  [31:0]                              hrdata;
  wire  [2:0]                               sdo;
  wire  [2:0]                               fco;
  wire  [2:0]                               bco;
  wire  [2:0]                               spp;
  wire  audpg_pkg::audpg_power_t            bp;
  wire  [95:0]                              mic_out;
  wire  [47:0]                              adc_out;
  wire                                      tx_pin;
  wire                                      rx_stream;
  wire  audpg_pkg::audpg_conv_sel_t [7:0]   cs;
  integer                                   seed      = 32'h90ee;
  int                                       errors    = 0;
  int                                       cmp_count = 0;
  logic [31:0]                              rd_q[$];

  // The single slave drives the bus ready line.
  assign hready = hreadyout;

  audpg_top audpg_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .serial_input_data_pin(sd_pin), .input_frame_clock_pin(fc_pin),
    .input_bit_clock_pin(bc_pin), .serial_input_data(sdo), .input_frame_clock(fco),
    .input_bit_clock(bco), .serial_in_path_power(spp), .block_power(bp),
    .mic_data_in(mic_in), .mic_data_out(mic_out), .tx_stream(tx_stream), .tx_pin(tx_pin),
    .rx_pin(rx_pin), .rx_stream(rx_stream), .adc_result_in(adc_in),
    .adc_result_out(adc_out), .conv_sel(cs)
  );

  always #10 hclk = ~hclk;

  // ============================================================
  // Compare tasks, bus task and read monitor
  // ============================================================
  task automatic chk_port(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected port value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_read(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected read data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Called just after a rising edge; the expected read value is queued at acceptance.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rd_busy <= !w;
    if (!w) rd_q.push_back(e);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_busy <= 1'b0;
  endtask

  always @(posedge hclk) begin
    if (rd_busy && hreadyout === 1'b1 && rd_q.size() > 0) begin
      chk_read(hrdata, rd_q.pop_front());
      chk_port(hresp, 128'h0);
    end
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // The whole sequence needs well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    $display("unexpected timeout at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    summarize();
  end

  // ============================================================
  // Main sequence
  // ============================================================
  initial begin
    logic [4:0]  ptab [6];
    logic [2:0]  stab [5];
    logic [4:0]  p;
    logic [2:0]  k3;
    logic [31:0] v;
    logic [95:0] nm;
    logic [47:0] na;
    logic [95:0] e_mic;
    logic [47:0] e_adc;
    logic [7:0]  e_sel [8];
    logic        ok;
    ptab = '{5'h1f, 5'h08, 5'h10, 5'h06, 5'h01, 5'h00};
    stab = '{3'h7, 3'h1, 3'h2, 3'h4, 3'h0};
    e_mic = 96'h0;
    e_adc = 48'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_port(bp, 128'h0);
    ahb(1'b0, A_PWR1, 32'h0, 32'h0);
    for (int n = 0; n < 8; n++) begin
      chk_port(cs[n], 128'h0);
      ahb(1'b0, A_SEL + 32'(4 * n), 32'h0, 32'h0);
    end
    $display("test reset_values done");

    // Upper data bits are random so that dropped reserved bits are exercised.
    for (int k = 0; k < 6; k++) begin
      p = ptab[k];
      v = $random(seed);
      ahb(1'b1, A_PWR1, {v[31:5], p}, 32'h0);
      ahb(1'b0, A_PWR1, 32'h0, {27'h0, p});
      nm = {$random(seed), $random(seed), $random(seed)};
      v = $random(seed);
      na = {v[15:0], 32'($random(seed))};
      mic_in <= nm;
      adc_in <= na;
      tx_stream <= v[16];
      rx_pin <= v[17];
      repeat (5) @(posedge hclk);
      if (p[3]) e_mic[47:0] = nm[47:0];
      if (p[4]) e_mic[95:48] = nm[95:48];
      if (p[0]) e_adc = na;
      chk_port(bp, {123'h0, p});
      chk_port(mic_out, {32'h0, e_mic});
      chk_port(tx_pin, {127'h0, p[2] & v[16]});
      chk_port(rx_stream, {127'h0, p[1] & v[17]});
      chk_port(adc_out, {80'h0, e_adc});
    end
    $display("test block_power done");

    // Clock pins must pass whatever the path enable says.
    for (int k = 0; k < 5; k++) begin
      v = $random(seed);
      ahb(1'b1, A_PWR0, {v[31:3], stab[k]}, 32'h0);
      ahb(1'b0, A_PWR0, 32'h0, {29'h0, stab[k]});
      sd_pin <= v[10:8] | 3'h7 & {3{k[0]}};
      fc_pin <= v[13:11];
      bc_pin <= v[16:14];
      repeat (6) @(posedge hclk);
      chk_port(spp, {125'h0, stab[k]});
      chk_port(sdo, {125'h0, sd_pin & stab[k]});
      chk_port({fco, bco}, {122'h0, fc_pin, bc_pin});
    end
    $display("test serial_paths done");

    // Selector n carries source kind n, then selectors 2 and 5 are rewritten as serial with pairs 24 and 0, so kinds 2 and 5 are not checked.
    for (int n = 0; n < 8; n++) begin
      v = $random(seed);
      k3 = 3'(n);
      e_sel[n] = {(n == 1) ? 5'd23 : v[7:3], k3};
      ahb(1'b1, A_SEL + 32'(4 * n), {v[31:8], e_sel[n]}, 32'h0);
    end
    e_sel[2] = {5'd24, 3'h1};
    e_sel[5] = {5'd0, 3'h1};
    ahb(1'b1, A_SEL + 32'h8, {24'h0, e_sel[2]}, 32'h0);
    ahb(1'b1, A_SEL + 32'h14, {24'h0, e_sel[5]}, 32'h0);
    for (int n = 0; n < 8; n++) begin
      ahb(1'b0, A_SEL + 32'(4 * n), 32'h0, {24'h0, e_sel[n]});
      k3 = e_sel[n][2:0];
      ok = k3 inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5} && !(k3 == 3'h1 && e_sel[n][7:3] > 5'd23);
      chk_port({cs[n].valid, cs[n].converter_source_kind}, {124'h0, ok, ok ? k3 : 3'h0});
      if (ok && k3 == 3'h1) begin
        chk_port({cs[n].converter_serial_pair_select, cs[n].first_serial_channel},
                 {117'h0, e_sel[n][7:3], e_sel[n][7:3], 1'b0});
      end
    end
    $display("test selectors done");

    // Unmapped places neither store nor disturb the neighbouring registers.
    ahb(1'b1, A_PWR1 + 32'h4, 32'hffffffff, 32'h0);
    ahb(1'b1, A_SEL + 32'h20, 32'hffffffff, 32'h0);
    ahb(1'b0, A_PWR1 + 32'h4, 32'h0, 32'h0);
    ahb(1'b0, A_SEL + 32'h20, 32'h0, 32'h0);
    ahb(1'b0, A_SEL + 32'h1c, 32'h0, {24'h0, e_sel[7]});
    ahb(1'b0, A_PWR1, 32'h0, 32'h0);
    $display("test unmapped done");
    repeat (2) @(posedge hclk);
    summarize();
  end
endmodule
